/* hdl/drive_run_ctrl.sv */
// run sequencer: run-enable gating, quick stop, dwell holds, slip frequency
`timescale 1ns/1ps
`default_nettype none
module drive_run_ctrl #(
    parameter int N_TERM = 11,
    parameter int DWELL_TICK = drive_run_pkg::DWELL_TICK_CYCLES,
    parameter int RAMP_TICK = drive_run_pkg::RAMP_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run_cmd,
    input wire logic [N_TERM-1:0] terminal_pins,
    input wire logic [N_TERM-1:0][drive_run_pkg::CODE_W-1:0] terminal_function_select,
    input wire logic input_qualified,
    input wire logic [1:0] disable_stop_mode,
    input wire logic [drive_run_pkg::TIME_W-1:0] quick_stop_time,
    input wire logic [drive_run_pkg::TIME_W-1:0] acc_time,
    input wire logic [drive_run_pkg::TIME_W-1:0] dec_time,
    input wire logic [drive_run_pkg::FREQ_W-1:0] max_freq,
    input wire logic [drive_run_pkg::FREQ_W-1:0] target_freq,
    input wire logic [drive_run_pkg::FREQ_W-1:0] acc_dwell_freq,
    input wire logic [drive_run_pkg::TIME_W-1:0] acc_dwell_time,
    input wire logic [drive_run_pkg::FREQ_W-1:0] dec_dwell_freq,
    input wire logic [drive_run_pkg::TIME_W-1:0] dec_dwell_time,
    input wire logic brake_control_active,
    input wire logic [2:0] control_mode,
    input wire logic [drive_run_pkg::FREQ_W-1:0] rated_freq,
    input wire logic [drive_run_pkg::RPM_W-1:0] rated_rpm,
    input wire logic [drive_run_pkg::POLE_W-1:0] pole_count,
    input wire logic [3:0] inertia_rate,
    output logic drive_enable,
    output logic [drive_run_pkg::FREQ_W-1:0] output_freq,
    output logic dwell_active,
    output logic run_enable_level,
    output drive_run_pkg::run_state_t run_state,
    output logic [drive_run_pkg::FREQ_W-1:0] slip_freq,
    output logic [1:0] inertia_class
);
    import drive_run_pkg::*;
    localparam int DT_W = $clog2(DWELL_TICK + 1);

    // limit a time setting to its documented maximum
    function automatic logic [TIME_W-1:0] clamp_time(input logic [TIME_W-1:0] t,
                                                     input logic [TIME_W-1:0] lim);
        clamp_time = (t > lim) ? lim : t;
    endfunction

    // true when a terminal carries the run-enable function
    function automatic logic is_run_enable(input logic [CODE_W-1:0] code);
        is_run_enable = (code == FUNC_RUN_ENABLE);
    endfunction

    ramp_if rif ();
    run_state_t state;               // sequencer state
    run_state_t next_state;          // state for the next edge
    logic [N_TERM-1:0] term_level;   // debounced terminal levels
    logic [N_TERM-1:0] term_assigned; // terminals set to run enable
    logic [DT_W-1:0] dwell_tick_cnt; // 100 ms prescaler
    logic [TIME_W-1:0] dwell_cnt;    // elapsed dwell, 0.1 s units

    ////////////////////////////////////////////////////////////////////////
    // terminal synchronisers, three stages, change once stages 2 and 3 agree
    genvar gi;
    generate
        for (gi = 0; gi < N_TERM; gi++) begin : g_term
            logic [2:0] sync;
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    sync <= 3'h0;
                    term_level[gi] <= 1'b0;
                end else begin
                    sync <= {sync[1:0], terminal_pins[gi]};
                    // accept a level only when stages agree
                    if (sync[1] == sync[2]) begin
                        term_level[gi] <= sync[2];
                    end
                end
            end
            assign term_assigned[gi] = is_run_enable(terminal_function_select[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // run-enable qualification
    wire any_assigned = |term_assigned;
    wire enable_seen = |(term_assigned & term_level);
    // gating needs both the qualified mode and an assigned terminal
    wire gate_off = input_qualified && any_assigned && !enable_seen;
    wire [TIME_W-1:0] qstop_clamped = clamp_time(quick_stop_time, QSTOP_TIME_MAX);
    wire [TIME_W-1:0] acc_dwell_lim = clamp_time(acc_dwell_time, DWELL_TIME_MAX);
    wire [TIME_W-1:0] dec_dwell_lim = clamp_time(dec_dwell_time, DWELL_TIME_MAX);

    ////////////////////////////////////////////////////////////////////////
    // dwell decisions
    wire acc_dwell_on = (acc_dwell_lim != '0) && !brake_control_active
                        && (target_freq > acc_dwell_freq);
    wire dec_dwell_on = (dec_dwell_lim != '0) && !brake_control_active
                        && (rif.freq > dec_dwell_freq);
    wire in_dwell = (state == ST_ACC_DWELL) || (state == ST_DEC_DWELL);
    wire [TIME_W-1:0] dwell_lim = (state == ST_ACC_DWELL) ? acc_dwell_lim : dec_dwell_lim;
    wire dwell_done = dwell_cnt >= dwell_lim;
    wire dwell_tick = (dwell_tick_cnt == DT_W'(DWELL_TICK - 1));
    wire motion_state = (state != ST_IDLE) && (state != ST_HALT_WAIT) && (state != ST_QSTOP);
    // stop command entry: dwell only if above the dwell frequency
    wire run_state_t stop_entry = dec_dwell_on ? ST_DEC_TO_DWELL : ST_STOPPING;
    wire resume_mode = (disable_stop_mode == STOP_QUICK_RESUME);
    wire at_zero = (rif.freq == '0);

    ////////////////////////////////////////////////////////////////////////
    // next-state selection
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                // a start needs the enable while gated
                if (run_cmd && !gate_off) begin
                    next_state = acc_dwell_on ? ST_ACC_TO_DWELL : ST_RUN;
                end
            end
            ST_ACC_TO_DWELL: begin
                if (brake_control_active) begin
                    next_state = ST_RUN;
                end else if (!run_cmd) begin
                    next_state = stop_entry;
                end else if (rif.at_target) begin
                    next_state = ST_ACC_DWELL;
                end
            end
            ST_ACC_DWELL: begin
                if (brake_control_active || dwell_done) begin
                    next_state = ST_RUN;
                end else if (!run_cmd) begin
                    next_state = stop_entry;
                end
            end
            ST_RUN: begin
                if (!run_cmd) begin
                    next_state = stop_entry;
                end
            end
            ST_DEC_TO_DWELL: begin
                // re-run goes straight to run, never an acceleration dwell
                if (run_cmd) begin
                    next_state = ST_RUN;
                end else if (brake_control_active) begin
                    next_state = ST_STOPPING;
                end else if (rif.at_target) begin
                    next_state = ST_DEC_DWELL;
                end
            end
            ST_DEC_DWELL: begin
                if (run_cmd) begin
                    next_state = ST_RUN;
                end else if (brake_control_active || dwell_done) begin
                    next_state = ST_STOPPING;
                end
            end
            ST_STOPPING: begin
                if (run_cmd) begin
                    next_state = ST_RUN;
                end else if (at_zero) begin
                    next_state = ST_IDLE;
                end
            end
            ST_QSTOP: begin
                // resume mode picks up again with enable back and run on
                if (resume_mode && !gate_off && run_cmd) begin
                    next_state = ST_RUN;
                end else if (at_zero && !(resume_mode && run_cmd)) begin
                    next_state = ST_HALT_WAIT;
                end
            end
            ST_HALT_WAIT: begin
                // wait for the run command to drop before a new start
                if (!run_cmd) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // enable loss while moving overrides everything else
        if (gate_off && motion_state) begin
            next_state = (disable_stop_mode == STOP_COAST) ? ST_HALT_WAIT : ST_QSTOP;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ramp steering
    always_comb begin
        case (state)
            ST_ACC_TO_DWELL, ST_ACC_DWELL: rif.target = acc_dwell_freq;
            ST_RUN: rif.target = target_freq;
            ST_DEC_TO_DWELL, ST_DEC_DWELL: rif.target = dec_dwell_freq;
            default: rif.target = '0;
        endcase
    end
    assign rif.up_time = acc_time;
    // quick-stop time only while quick stopping
    assign rif.down_time = (state == ST_QSTOP) ? qstop_clamped : dec_time;
    assign rif.max_freq = max_freq;
    assign rif.clear = (state == ST_IDLE) || (state == ST_HALT_WAIT);

    freq_ramp #(
        .TICK_CYCLES(RAMP_TICK)
    ) u_ramp (
        .clk(clk),
        .rst_b(rst_b),
        .rif(rif)
    );

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dwell timer, counts 100 ms ticks while holding
    always_ff @(posedge clk) begin
        if (!rst_b || !in_dwell || (next_state != state)) begin
            dwell_tick_cnt <= '0;
            dwell_cnt <= '0;
        end else if (dwell_tick) begin
            dwell_tick_cnt <= '0;
            dwell_cnt <= dwell_cnt + TIME_W'(1);
        end else begin
            dwell_tick_cnt <= dwell_tick_cnt + DT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slip frequency, 0.01 Hz units, clamped at zero
    wire [31:0] sync_freq = (32'(rated_rpm) * 32'(pole_count) * 32'(FREQ_SCALE))
                            / 32'(SLIP_DIV);
    wire [31:0] slip_calc = (32'(rated_freq) > sync_freq) ? 32'(rated_freq) - sync_freq
                                                          : 32'h0000_0000;
    wire slip_on = (control_mode == CTRL_SLIP_COMP);
    wire [1:0] inertia_dec = (inertia_rate == '0) ? INERTIA_BELOW :
                             (inertia_rate == INERTIA_ABOUT_TEN) ? INERTIA_EQUAL
                                                                 : INERTIA_ABOVE;

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            drive_enable <= 1'b0;
            output_freq <= '0;
            dwell_active <= 1'b0;
            run_enable_level <= 1'b0;
            run_state <= ST_IDLE;
            slip_freq <= '0;
            inertia_class <= INERTIA_BELOW;
        end else begin
            drive_enable <= (next_state != ST_IDLE) && (next_state != ST_HALT_WAIT);
            output_freq <= rif.freq;
            dwell_active <= in_dwell;
            run_enable_level <= !gate_off;
            run_state <= state;
            slip_freq <= slip_on ? slip_calc[FREQ_W-1:0] : '0;
            inertia_class <= inertia_dec;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_coast_drive_off: assert property (
        (gate_off && motion_state && disable_stop_mode == STOP_COAST)
        |=> (state == ST_HALT_WAIT && !drive_enable) ##2 (output_freq == '0))
        else $error("coast did not block the drive");
    a_gated_no_start: assert property (
        (state == ST_IDLE && gate_off) |=> (state == ST_IDLE))
        else $error("start taken while run enable is off");
    a_ungated_start: assert property (
        (state == ST_IDLE && !input_qualified && run_cmd)
        |=> (state == ST_RUN || state == ST_ACC_TO_DWELL))
        else $error("run command not accepted with gating off");
    a_halt_no_restart: assert property (
        (state == ST_HALT_WAIT && run_cmd) |=> (state == ST_HALT_WAIT))
        else $error("restart without a new run command");
    a_qstop_resume: assert property (
        (state == ST_QSTOP && resume_mode && !gate_off && run_cmd) |=> (state == ST_RUN))
        else $error("quick stop did not resume");
    a_qstop_time_sel: assert property (
        (state == ST_QSTOP) |-> (rif.down_time == qstop_clamped))
        else $error("quick stop not using its own time");
    a_acc_dwell_hold: assert property (
        (state == ST_ACC_DWELL && $past(state) == ST_ACC_DWELL && $stable(acc_dwell_freq))
        |-> $stable(rif.freq))
        else $error("frequency moved during acceleration dwell");
    a_dwell_zero_off: assert property (
        (state == ST_IDLE && acc_dwell_lim == '0) |=> (state != ST_ACC_TO_DWELL))
        else $error("dwell entered with zero time");
    a_dec_dwell_entry: assert property (
        $rose(state == ST_DEC_TO_DWELL) |-> !$past(run_cmd))
        else $error("deceleration dwell without stop command");
    a_brake_no_dwell: assert property (
        (brake_control_active && in_dwell) |=> !in_dwell)
        else $error("dwell held with brake control active");
    a_slip_value: assert property (
        slip_on |=> (slip_freq == $past(slip_calc[FREQ_W-1:0])))
        else $error("slip frequency mismatch");

    c_coast_stop: cover property (gate_off && motion_state && disable_stop_mode == STOP_COAST);
    c_qstop_resumed: cover property (state == ST_QSTOP ##1 state == ST_RUN);
    c_acc_dwell_done: cover property (state == ST_ACC_DWELL ##1 state == ST_RUN);
    c_dec_dwell_done: cover property (state == ST_DEC_DWELL ##1 state == ST_STOPPING);
endmodule
`default_nettype wire

/* hdl/drive_run_pkg.sv */
// shared constants, settings encodings and state type for the run sequencer
package drive_run_pkg;
    // setting widths: frequency in 0.01 Hz, times in 0.1 s
    localparam int FREQ_W = 16;
    localparam int TIME_W = 13;
    localparam int CODE_W = 8;
    localparam int RPM_W = 16;
    localparam int POLE_W = 8;
    // terminal function code that makes a terminal the run-enable input
    localparam logic [CODE_W-1:0] FUNC_RUN_ENABLE = 8'h0D;
    // behaviour when the run-enable terminal drops
    localparam logic [1:0] STOP_COAST = 2'h0;
    localparam logic [1:0] STOP_QUICK = 2'h1;
    localparam logic [1:0] STOP_QUICK_RESUME = 2'h2;
    // upper limits of the time settings, 0.1 s units (600 s and 10 s)
    localparam logic [TIME_W-1:0] QSTOP_TIME_MAX = 13'h1770;
    localparam logic [TIME_W-1:0] DWELL_TIME_MAX = 13'h0064;
    // control mode value that selects slip compensation
    localparam logic [2:0] CTRL_SLIP_COMP = 3'h2;
    // slip formula: fs = fr - rpm * poles / 120, frequency scaled by 100
    localparam int SLIP_DIV = 120;
    localparam int FREQ_SCALE = 100;
    // load inertia setting and its classes
    localparam logic [3:0] INERTIA_ABOUT_TEN = 4'h1;
    localparam logic [1:0] INERTIA_BELOW = 2'h0;
    localparam logic [1:0] INERTIA_EQUAL = 2'h1;
    localparam logic [1:0] INERTIA_ABOVE = 2'h2;
    // timing: 100 MHz clock, ramp step tick 100 us, dwell tick 100 ms
    localparam int CLK_PERIOD_NS = 10;
    localparam int RAMP_TICK_US = 100;
    localparam int DWELL_TICK_MS = 100;
    localparam int RAMP_TICK_CYCLES = RAMP_TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int DWELL_TICK_CYCLES = DWELL_TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RAMP_TICKS_PER_TENTH = DWELL_TICK_MS * 1000 / RAMP_TICK_US;
    // run sequencer states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ACC_TO_DWELL,
        ST_ACC_DWELL,
        ST_RUN,
        ST_DEC_TO_DWELL,
        ST_DEC_DWELL,
        ST_STOPPING,
        ST_QSTOP,
        ST_HALT_WAIT
    } run_state_t;
endpackage

/* hdl/ramp_if.sv */
// link between the run sequencer and the frequency ramp
`timescale 1ns/1ps
`default_nettype none
interface ramp_if;
    import drive_run_pkg::*;
    logic [FREQ_W-1:0] target;    // frequency to head for
    logic [TIME_W-1:0] up_time;   // full-scale rise time
    logic [TIME_W-1:0] down_time; // full-scale fall time
    logic [FREQ_W-1:0] max_freq;  // full-scale frequency
    logic clear;                  // force frequency to zero
    logic [FREQ_W-1:0] freq;      // present ramp frequency
    logic at_target;              // frequency equals target
    modport ctrl (output target, up_time, down_time, max_freq, clear,
                  input freq, at_target);
    modport gen (input target, up_time, down_time, max_freq, clear,
                 output freq, at_target);
endinterface
`default_nettype wire

/* hdl/freq_ramp.sv */
// linear frequency ramp, one 0.01 Hz step at most per ramp tick while the selected time is nonzero
`timescale 1ns/1ps
`default_nettype none
module freq_ramp #(
    parameter int TICK_CYCLES = drive_run_pkg::RAMP_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    ramp_if.gen rif
);
    import drive_run_pkg::*;
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam int SPAN_W = TIME_W + 11;
    localparam int ACC_W = SPAN_W + 1;

    logic [TICK_W-1:0] tick_cnt; // ramp tick prescaler
    logic [ACC_W-1:0] accum;     // rate accumulator
    logic [FREQ_W-1:0] freq;     // present frequency
    wire tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
    wire going_up = rif.target > freq;
    wire [TIME_W-1:0] sel_time = going_up ? rif.up_time : rif.down_time;
    // ramp ticks that a full-scale change takes
    wire [SPAN_W-1:0] span = SPAN_W'(sel_time) * SPAN_W'(RAMP_TICKS_PER_TENTH);
    wire [ACC_W-1:0] accum_sum = accum + ACC_W'(rif.max_freq);
    wire step_due = accum_sum >= ACC_W'(span);
    wire [FREQ_W-1:0] step_freq = going_up ? freq + 16'h0001 : freq - 16'h0001;

    assign rif.freq = freq;
    assign rif.at_target = (freq == rif.target);

    ////////////////////////////////////////////////////////////////////////
    // tick prescaler
    always_ff @(posedge clk) begin
        if (!rst_b || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + TICK_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frequency stepping; a zero time jumps straight to target
    always_ff @(posedge clk) begin
        if (!rst_b || rif.clear) begin
            freq <= '0;
            accum <= '0;
        end else if (freq == rif.target) begin
            accum <= '0;
        end else if (sel_time == '0) begin
            freq <= rif.target;
        end else if (tick && step_due) begin
            // one step, remainder carried
            freq <= step_freq;
            accum <= accum_sum - ACC_W'(span);
        end else if (tick) begin
            accum <= accum_sum;
        end
    end
endmodule
`default_nettype wire

/* tb/motor_stage.sv */
// power stage and motor stand-in driven by the run sequencer outputs
`timescale 1ns/1ps
`default_nettype none
module motor_stage (
    input wire logic clk,
    input wire logic drive_enable,
    input wire logic [15:0] output_freq,
    output var int speed,
    output var int faults
);
    int prev = 0; // frequency seen one clock earlier
    initial speed = 0;
    initial faults = 0;
    // rotor follows the drive; without drive it coasts down slowly
    always @(posedge clk) begin
        if (drive_enable === 1'b1) begin
            speed <= int'(output_freq);
            // a ramped output never jumps by more than one step
            if (int'(output_freq) - prev > 1 || prev - int'(output_freq) > 1)
                faults <= faults + 1;
        end else if (speed > 0) begin
            speed <= speed - 1;
        end
        prev <= int'(output_freq);
    end
endmodule
`default_nettype wire

/* tb/drive_run_gating_dwell_slip_test.sv */
// self-checking bench: run gating, stop modes, dwell holds, slip and inertia
`timescale 1ns/1ps
`default_nettype none
module drive_run_gating_dwell_slip_test;
    import drive_run_pkg::*;
    logic clk, rst_b, run_cmd, input_qualified, brake_control_active, drive_enable, dwell_active;
    logic [10:0] terminal_pins;
    logic [10:0][CODE_W-1:0] terminal_function_select;
    logic [1:0] disable_stop_mode, inertia_class;
    logic [TIME_W-1:0] acc_dwell_time, dec_dwell_time;
    logic [FREQ_W-1:0] tgt, acc_dwell_freq, dec_dwell_freq, output_freq, slip_freq, rated_freq;
    logic run_enable_level; // 1 while runs are not gated
    logic [TIME_W-1:0] quick_stop_time; // deceleration time on enable loss
    int f, f0; // rated frequency setting, frequency at quick-stop entry
    logic [2:0] control_mode;
    logic [RPM_W-1:0] rated_rpm;
    logic [POLE_W-1:0] pole_count;
    logic [3:0] inertia_rate;
    run_state_t run_state;
    int err_count = 0, checks = 0, seed = 48, dwell_cnt = 0, ref_cnt, speed, faults, r, p, e;
    drive_run_ctrl #(.DWELL_TICK(10), .RAMP_TICK(4)) uut (.clk(clk), .rst_b(rst_b),
        .run_cmd(run_cmd), .terminal_pins(terminal_pins),
        .terminal_function_select(terminal_function_select), .input_qualified(input_qualified),
        .disable_stop_mode(disable_stop_mode), .quick_stop_time(quick_stop_time),
        .acc_time(13'h0001), .dec_time(13'h0001), .max_freq(16'h03E8), .target_freq(tgt),
        .acc_dwell_freq(acc_dwell_freq), .acc_dwell_time(acc_dwell_time),
        .dec_dwell_freq(dec_dwell_freq), .dec_dwell_time(dec_dwell_time),
        .brake_control_active(brake_control_active), .control_mode(control_mode),
        .rated_freq(rated_freq), .rated_rpm(rated_rpm), .pole_count(pole_count),
        .inertia_rate(inertia_rate), .drive_enable(drive_enable), .output_freq(output_freq),
        .dwell_active(dwell_active), .run_enable_level(run_enable_level), .run_state(run_state),
        .slip_freq(slip_freq), .inertia_class(inertia_class));
    motor_stage load (.clk(clk), .drive_enable(drive_enable), .output_freq(output_freq),
        .speed(speed), .faults(faults));
    // clock
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // count cycles spent in any dwell hold
    always @(posedge clk) if (dwell_active === 1'b1) dwell_cnt <= dwell_cnt + 1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            err_count++;
            $display("[ERR] %0t seen %0h want %0h", $time, seen, want);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // bounded wait: sel 0 state, 1 dwell flag, 2 output frequency
    task automatic wait_for(input int sel, input logic [31:0] val, input int n);
        logic [31:0] now;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            now = sel == 0 ? 32'(run_state) : sel == 1 ? 32'(dwell_active) : 32'(output_freq);
            if (now === val)
                return;
        end
        err_count++;
        $display("[ERR] %0t wait ran out", $time);
        give_verdict();
    endtask
    // full start and stop with the dwell settings in force
    task automatic start_stop();
        run_cmd <= 1'b1;
        wait_for(2, tgt, 3000);
        run_cmd <= 1'b0;
        wait_for(0, ST_IDLE, 3000);
    endtask
    initial begin
        {rst_b, run_cmd, input_qualified, brake_control_active, terminal_pins} = '0;
        terminal_function_select = '0;
        disable_stop_mode = STOP_COAST;
        {acc_dwell_time, dec_dwell_time} = {13'h0001, 13'h0001};
        {acc_dwell_freq, dec_dwell_freq, tgt} = {16'h0064, 16'h0064, 16'h012C};
        {control_mode, rated_rpm, pole_count, inertia_rate} = {3'h0, 16'h06CC, 8'h04, 4'h0};
        // quick stop twice as slow as the normal fall, so the two are told apart
        {rated_freq, quick_stop_time} = {16'h1770, 13'h0002};
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        // slip and inertia against the integer model
        for (int i = 0; i < 18; i++) begin
            r = 6 * (1 + $unsigned($random(seed)) % 300);
            p = 2 * (1 + $unsigned($random(seed)) % 4);
            f = 5000 + $unsigned($random(seed)) % 2000;
            @(posedge clk);
            control_mode <= i % 4 == 3 ? 3'h0 : CTRL_SLIP_COMP;
            {rated_rpm, pole_count, inertia_rate} <= {16'(r), 8'(p), 4'(i % 9)};
            rated_freq <= 16'(f);
            repeat (4) @(posedge clk);
            #1;
            e = (i % 4 == 3 || r * p * 5 / 6 > f) ? 0 : f - r * p * 5 / 6;
            chk(slip_freq, e);
            chk(inertia_class, i % 9 > 1 ? 2 : i % 9);
        end
        // dwell on start and on stop
        run_cmd <= 1'b1;
        wait_for(1, 1, 3000);
        chk(output_freq, acc_dwell_freq);
        wait_for(2, tgt, 3000);
        run_cmd <= 1'b0;
        wait_for(1, 1, 3000);
        chk(output_freq, dec_dwell_freq);
        wait_for(0, ST_STOPPING, 300);
        ref_cnt = dwell_cnt;
        run_cmd <= 1'b1;
        wait_for(2, tgt, 3000);
        chk(dwell_cnt, ref_cnt);
        tgt <= 16'h0032;
        wait_for(2, 16'h0032, 3000);
        chk(dwell_cnt, ref_cnt);
        tgt <= 16'h012C;
        wait_for(2, tgt, 3000);
        run_cmd <= 1'b0;
        wait_for(0, ST_IDLE, 3000);
        // run gating by the coded terminal, pin low
        terminal_function_select[3] <= FUNC_RUN_ENABLE;
        for (int q = 0; q < 2; q++) begin
            input_qualified <= 1'(q);
            run_cmd <= 1'b1;
            repeat (40) @(posedge clk);
            #1;
            chk(drive_enable, q == 0);
            chk(run_enable_level, q == 0);
            run_cmd <= 1'b0;
            wait_for(0, ST_IDLE, 3000);
        end
        terminal_pins[3] <= 1'b1;
        run_cmd <= 1'b1;
        wait_for(0, ST_RUN, 3000);
        // enable loss under each stop behaviour
        for (int m = 0; m < 3; m++) begin
            disable_stop_mode <= 2'(m);
            terminal_pins[3] <= 1'b0;
            wait_for(0, m == 0 ? ST_HALT_WAIT : ST_QSTOP, 12);
            chk(drive_enable, m != 0);
            if (m == 1) begin
                f0 = output_freq;
                repeat (80) @(posedge clk);
                #1;
                // 80 cycles = 20 ramp ticks; 0.2 s over full scale is one step per 2 ticks
                chk(f0 - int'(output_freq), 80 / 4 / 2);
                wait_for(0, ST_HALT_WAIT, 3000);
            end
            terminal_pins[3] <= 1'b1;
            if (m == 2)
                wait_for(0, ST_RUN, 3000);
            repeat (20) @(posedge clk);
            #1;
            chk(run_state, m == 2 ? ST_RUN : ST_HALT_WAIT);
            run_cmd <= 1'b0;
            wait_for(0, ST_IDLE, 3000);
            run_cmd <= 1'b1;
            wait_for(0, ST_RUN, 3000);
        end
        run_cmd <= 1'b0;
        wait_for(0, ST_IDLE, 3000);
        // brake control on, then zero dwell times: no hold either way
        ref_cnt = dwell_cnt;
        brake_control_active <= 1'b1;
        start_stop();
        chk(dwell_cnt, ref_cnt);
        {brake_control_active, acc_dwell_time, dec_dwell_time} <= '0;
        start_stop();
        chk(dwell_cnt, ref_cnt);
        chk(faults, 0);
        give_verdict();
    end
endmodule
`default_nettype wire
